// ==== rtl/ptr_pkg.sv ====
// Package with register map, codes, timing and carrier types of the thermometer readout.
package ptr_pkg;

   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [7:0] ADDR_COMMAND = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SAMPLE = 8'h08;
   localparam logic [7:0] ADDR_TEMP_RESULT = 8'h0C;
   localparam logic [7:0] ADDR_RESIDUAL = 8'h10;
   localparam logic [7:0] ADDR_ALARM_LIMITS = 8'h14;
   localparam logic [7:0] ADDR_DEVICE_CODE_LO = 8'h18;
   localparam logic [7:0] ADDR_DEVICE_CODE_HI = 8'h1C;

   // Command codes written to the command register.
   localparam logic [7:0] CMD_START_CONV = 8'h44;
   localparam logic [7:0] CMD_COPY_NV = 8'h48;

   // Result and scratchpad constants.
   localparam logic [15:0] TEMP_RESET = 16'h00AA;
   localparam logic [7:0] COUNTS_PER_DEGREE = 8'h10;
   localparam logic [7:0] RESIDUAL_RESET = 8'h0C;
   localparam logic [7:0] ALARM_HI_RESET = 8'h4B;
   localparam logic [7:0] ALARM_LO_RESET = 8'h46;

   // Status register fields.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_NV_BUSY_BIT = 2;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing at the 50 MHz clock.
   localparam int CLOCK_MHZ = 50;
   localparam int CONV_TIME_MS = 750;
   localparam int NV_WRITE_TIME_MS = 10;
   localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CLOCK_MHZ;
   localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * 1000 * CLOCK_MHZ;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_NV_WRITE = 2'b10
   } ptr_state_t;

   // Sample that the converter front end presents.
   typedef struct packed
   {
      logic [8:0] temp;
      logic [7:0] residual;
   } ptr_sample_t;

   // Scratchpad bytes 0, 1 and 6 as seen by software.
   typedef struct packed
   {
      logic [15:0] temp;
      logic [7:0] residual;
   } ptr_result_t;

endpackage

// ==== rtl/ptr_readout.sv ====
// Thermometer conversion control and result registers behind an AXI4-Lite slave.
//
// How it works
// - Writing start-conversion code 44h begins a measurement and conversion.
// - On completion the result is written, then the block returns idle.
// - After reset the block idles and converts only when commanded.
// - The result is held as 16-bit sign-extended two's complement.
// - Nine significant bits; bit 0 weighs half a degree.
// - All bits of the upper byte repeat the sign.
// - Counts-per-degree always reads sixteen.
// - A conversion completes within 750 ms of its start.
// - A unique 64-bit code identifies the device among many.
// - Alarm limit bytes are kept in storage that survives reset.
// - At reset the result reads plus eighty-five degrees, 00AAh.
// - Result low byte then high byte at scratchpad bytes 0, 1, read-only.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module ptr_readout #(
   parameter int CONV_CYCLES = ptr_pkg::CONV_CYCLES,
   parameter int NV_WRITE_CYCLES = ptr_pkg::NV_WRITE_CYCLES,
   parameter logic [63:0] DEVICE_CODE = 64'h0000_0000_0000_00A5
)
(
   // Clock and reset.
   input wire logic I_CLOCK,
   input wire logic I_RST_B,
   // AXI4-Lite write channels.
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // AXI4-Lite read channels.
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // Converter front end, asynchronous to the clock.
   input wire logic [16:0] I_SENSOR,
   // Conversion state.
   output logic O_CONV_BUSY
);

   initial
   begin
      if (CONV_CYCLES < 2 || NV_WRITE_CYCLES < 2)
      begin
         $error("Conversion and write counts must be at least two cycles.");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sensor synchroniser.

   logic [16:0] sens_meta_q;
   logic [16:0] sens_sync_q;
   ptr_pkg::ptr_sample_t sample;

   always_ff @(posedge I_CLOCK)
   begin
      sens_meta_q <= I_SENSOR;
      sens_sync_q <= sens_meta_q;
   end

   assign sample = ptr_pkg::ptr_sample_t'(sens_sync_q);

   ////////////////////////////////////////////////////////////////////////////
   // AXI write path.

   logic aw_held_q;
   logic w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   wire aw_take = I_AWVALID && !aw_held_q && !bvalid_q;
   wire w_take = I_WVALID && !w_held_q && !bvalid_q;
   wire wr_go = aw_held_q && w_held_q && !bvalid_q;

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a[1:0] == 2'h0) && (a <= ptr_pkg::ADDR_DEVICE_CODE_HI);
   endfunction

   wire cmd_wr = wr_go && aw_addr_q == ptr_pkg::ADDR_COMMAND && w_strb_q[0];
   wire lim_wr = wr_go && aw_addr_q == ptr_pkg::ADDR_ALARM_LIMITS;
   wire start_conv = cmd_wr && w_data_q[7:0] == ptr_pkg::CMD_START_CONV;
   wire start_copy = cmd_wr && w_data_q[7:0] == ptr_pkg::CMD_COPY_NV;

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_B)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= ptr_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= I_AWADDR;
         end
         if (w_take)
         begin
            w_held_q <= 1'b1;
            w_data_q <= I_WDATA;
            w_strb_q <= I_WSTRB;
         end
         if (wr_go)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= known_addr(aw_addr_q) ? ptr_pkg::RESP_OKAY : ptr_pkg::RESP_SLVERR;
         end
         else if (bvalid_q && I_BREADY)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign O_AWREADY = !aw_held_q && !bvalid_q;
   assign O_WREADY = !w_held_q && !bvalid_q;
   assign O_BVALID = bvalid_q;
   assign O_BRESP = bresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer.

   ptr_pkg::ptr_state_t state_q;
   ptr_pkg::ptr_state_t state_d;
   logic [31:0] timer_q;
   logic [31:0] timer_d;
   ptr_pkg::ptr_result_t result_q;
   logic done_q;
   logic [7:0] alarm_hi_q;
   logic [7:0] alarm_lo_q;
   logic [15:0] nv_limits_q;

   wire timer_end = timer_q == 32'h0000_0001;
   wire conv_end = state_q == ptr_pkg::ST_CONVERT && timer_end;
   wire nv_end = state_q == ptr_pkg::ST_NV_WRITE && timer_end;
   // Sign of the nine-bit sample spread over the upper byte.
   wire [15:0] temp_ext = {{7{sample.temp[8]}}, sample.temp};

   always_comb
   begin
      state_d = state_q;
      timer_d = (timer_q != 32'h0000_0000) ? timer_q - 32'h0000_0001 : timer_q;
      case (state_q)
         ptr_pkg::ST_IDLE:
         begin
            if (start_conv)
            begin
               state_d = ptr_pkg::ST_CONVERT;
               timer_d = 32'(CONV_CYCLES);
            end
            else if (start_copy)
            begin
               state_d = ptr_pkg::ST_NV_WRITE;
               timer_d = 32'(NV_WRITE_CYCLES);
            end
         end
         ptr_pkg::ST_CONVERT:
         begin
            if (timer_end)
            begin
               state_d = ptr_pkg::ST_IDLE;
            end
         end
         ptr_pkg::ST_NV_WRITE:
         begin
            if (timer_end)
            begin
               state_d = ptr_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_d = ptr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_B)
      begin
         state_q <= ptr_pkg::ST_IDLE;
         timer_q <= 32'h0000_0000;
         result_q <= {ptr_pkg::TEMP_RESET, ptr_pkg::RESIDUAL_RESET};
         done_q <= 1'b0;
         O_CONV_BUSY <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         timer_q <= timer_d;
         O_CONV_BUSY <= state_d == ptr_pkg::ST_CONVERT;
         if (conv_end)
         begin
            result_q <= {temp_ext, sample.residual};
         end
         if (conv_end)
         begin
            done_q <= 1'b1;
         end
         else if (start_conv && state_q == ptr_pkg::ST_IDLE)
         begin
            done_q <= 1'b0;
         end
      end
   end

   // Limits and their stored copy have no reset so they survive it.
   always_ff @(posedge I_CLOCK)
   begin
      if (lim_wr && w_strb_q[0])
      begin
         alarm_lo_q <= w_data_q[7:0];
      end
      if (lim_wr && w_strb_q[1])
      begin
         alarm_hi_q <= w_data_q[15:8];
      end
      if (nv_end)
      begin
         nv_limits_q <= {alarm_hi_q, alarm_lo_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI read path.

   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] rd_mux;

   wire ar_take = I_ARVALID && !rvalid_q;
   wire [2:0] stat_bits = {state_q == ptr_pkg::ST_NV_WRITE, done_q,
                           state_q == ptr_pkg::ST_CONVERT};

   always_comb
   begin
      case (I_ARADDR)
         ptr_pkg::ADDR_STATUS: rd_mux = {29'h0, stat_bits};
         ptr_pkg::ADDR_SAMPLE: rd_mux = {8'h00, ptr_pkg::COUNTS_PER_DEGREE,
                                         result_q.residual, 8'h00};
         ptr_pkg::ADDR_TEMP_RESULT: rd_mux = {16'h0000, result_q.temp};
         ptr_pkg::ADDR_ALARM_LIMITS: rd_mux = {nv_limits_q, alarm_hi_q, alarm_lo_q};
         ptr_pkg::ADDR_DEVICE_CODE_LO: rd_mux = DEVICE_CODE[31:0];
         ptr_pkg::ADDR_DEVICE_CODE_HI: rd_mux = DEVICE_CODE[63:32];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_B)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ptr_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= known_addr(I_ARADDR) ? ptr_pkg::RESP_OKAY : ptr_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && I_RREADY)
      begin
         rvalid_q <= 1'b0;
      end
   end

   assign O_ARREADY = !rvalid_q;
   assign O_RVALID = rvalid_q;
   assign O_RDATA = rdata_q;
   assign O_RRESP = rresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   chk_conv_start: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      start_conv && state_q == ptr_pkg::ST_IDLE |=> O_CONV_BUSY)
      else $error("Start code did not begin a conversion.");

   chk_idle_after: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      conv_end |=> state_q == ptr_pkg::ST_IDLE && done_q)
      else $error("Block did not return idle after conversion.");

   chk_no_spurious: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      state_q == ptr_pkg::ST_IDLE && !start_conv |=> state_q != ptr_pkg::ST_CONVERT)
      else $error("Conversion began without a command.");

   chk_sign_byte: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      result_q.temp[15:8] == 8'h00 || result_q.temp[15:8] == 8'hFF)
      else $error("Upper result byte is not a pure sign.");

   chk_sign_match: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      result_q.temp[15] == result_q.temp[8])
      else $error("Result is not sign-extended.");

   chk_count_const: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      ar_take && I_ARADDR == ptr_pkg::ADDR_SAMPLE |=> rdata_q[23:16] == ptr_pkg::COUNTS_PER_DEGREE)
      else $error("Counts-per-degree did not read sixteen.");

   chk_conv_bound: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      state_q == ptr_pkg::ST_CONVERT |-> timer_q <= 32'(CONV_CYCLES) && timer_q != 0)
      else $error("Conversion timer out of range.");

   chk_result_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      !conv_end |=> $stable(result_q))
      else $error("Result changed outside conversion end.");

   chk_result_load: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
      conv_end |=> result_q.temp[8:0] == $past(sample.temp))
      else $error("Result does not match the sampled reading.");

endmodule

// ==== sim/ptr_sensor_model.sv ====
// Converter front end model that presents a temperature sample and residual count.
`timescale 1ns/1ps

module ptr_sensor_model
(
   // Requested sample.
   input wire logic [8:0] i_temp,
   input wire logic [7:0] i_residual,
   // Sample toward the readout.
   output logic [16:0] o_sensor
);
   ptr_pkg::ptr_sample_t sample;
   assign sample.temp = i_temp;
   assign sample.residual = i_residual;
   assign o_sensor = sample;
endmodule

// ==== sim/ptr_readout_bench.sv ====
// Self-checking testbench for the thermometer readout block.
`timescale 1ns/1ps

module ptr_readout_bench;
   localparam int CONV = 20;
   // Arbitrary device code value.
   localparam logic [63:0] CODE = 64'h0123_4567_89AB_CDEF;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [8:0] temp = 9'h000;
   logic [7:0] resid = 8'h00;
   logic [16:0] sensor;
   logic awready, wready, bvalid, arready, rvalid, busy;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   int failures = 0;
   int n_compared = 0;
   int busy_cnt = 0;
   int seed = 32'h6821926f;
   logic [8:0] corner [7] = '{9'h000, 9'h1FF, 9'h032, 9'h1CE, 9'h192, 9'h0FF, 9'h100};

   initial
   begin
      forever #10 clk = ~clk;
   end

   always @(negedge clk)
   begin
      if (busy === 1'b1) busy_cnt++;
   end

   ptr_sensor_model MODEL (.i_temp(temp), .i_residual(resid), .o_sensor(sensor));

   ptr_readout #(.CONV_CYCLES(CONV), .NV_WRITE_CYCLES(10), .DEVICE_CODE(CODE)) DUT (
      .I_CLOCK(clk), .I_RST_B(rst_b),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_SENSOR(sensor), .O_CONV_BUSY(busy));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] sext(input logic [8:0] t);
      return {{7{t[8]}}, t};
   endfunction

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   // Handshakes are judged on the values that stand at the rising edge.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axi_rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // Runs one conversion; a second start while busy must not restart it.
   task automatic convert(input logic [8:0] t, input logic [7:0] c);
      logic [15:0] old;
      int n;
      temp <= t;
      resid <= c;
      axi_rd(ptr_pkg::ADDR_TEMP_RESULT);
      old = d[15:0];
      busy_cnt = 0;
      axi_wr(ptr_pkg::ADDR_COMMAND, {24'h0, ptr_pkg::CMD_START_CONV});
      axi_rd(ptr_pkg::ADDR_TEMP_RESULT);
      chk("held result", {16'h0, old}, {16'h0, d[15:0]});
      axi_wr(ptr_pkg::ADDR_COMMAND, {24'h0, ptr_pkg::CMD_START_CONV});
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (busy !== 1'b0 && n < 200);
      @(posedge clk);
      chk("busy cycles", CONV, busy_cnt);
      axi_rd(ptr_pkg::ADDR_TEMP_RESULT);
      chk("result", {16'h0, sext(t)}, {16'h0, d[15:0]});
      axi_rd(ptr_pkg::ADDR_STATUS);
      chk("status", 32'h2, d & 32'h7);
      axi_rd(ptr_pkg::ADDR_SAMPLE);
      chk("counts", {16'h0, ptr_pkg::COUNTS_PER_DEGREE, c}, {16'h0, d[23:8]});
   endtask

   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      axi_rd(ptr_pkg::ADDR_TEMP_RESULT);
      chk("reset result", 32'h00AA, {16'h0, d[15:0]});
      axi_rd(ptr_pkg::ADDR_SAMPLE);
      chk("reset counts", 32'h100C, {16'h0, d[23:8]});
      repeat (30) @(posedge clk);
      chk("idle busy", 0, busy_cnt);
      $display("test reset done");
      for (int i = 0; i < 7; i++) convert(corner[i], 8'($random(seed)));
      for (int i = 0; i < 6; i++) convert(9'($random(seed)), 8'($random(seed)));
      $display("test conversions done");
      axi_rd(ptr_pkg::ADDR_DEVICE_CODE_LO);
      chk("code low", CODE[31:0], d);
      axi_rd(ptr_pkg::ADDR_DEVICE_CODE_HI);
      chk("code high", CODE[63:32], d);
      axi_rd(8'h20);
      chk("unmapped resp", {30'h0, ptr_pkg::RESP_SLVERR}, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      axi_wr(8'h22, 32'h0);
      chk("unmapped wr resp", {30'h0, ptr_pkg::RESP_SLVERR}, {30'h0, r});
      $display("test map done");
      axi_wr(ptr_pkg::ADDR_ALARM_LIMITS, 32'h0000_4B46);
      axi_wr(ptr_pkg::ADDR_COMMAND, {24'h0, ptr_pkg::CMD_COPY_NV});
      axi_rd(ptr_pkg::ADDR_STATUS);
      chk("copy busy", 32'h4, d & 32'h4);
      repeat (20) @(posedge clk);
      axi_rd(ptr_pkg::ADDR_ALARM_LIMITS);
      chk("limits copied", 32'h4B46_4B46, d);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      axi_rd(ptr_pkg::ADDR_TEMP_RESULT);
      chk("rerun result", {16'h0, ptr_pkg::TEMP_RESET}, d);
      axi_rd(ptr_pkg::ADDR_ALARM_LIMITS);
      chk("limits kept", 32'h4B46_4B46, d);
      $display("test storage done");
      stop_test;
   end

   initial
   begin
      #1_000_000;
      failures++;
      stop_test;
   end
endmodule
